// >>> verilog/hub_boot_cfg.svh
// Offsets, field values, reset values and timing counts of the boot sequencer.
// Assumes a 32-bit AHB-Lite register window; indices are word indices.
`ifndef HUB_BOOT_CFG_SVH
`define HUB_BOOT_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_STAGE 10'h000
`define IDX_CONFIG 10'h001
`define IDX_GPIO_DIR 10'h002
`define IDX_GPIO_OUT 10'h003
`define IDX_GPIO_PULL_EN 10'h004
`define IDX_GPIO_PULL_UP 10'h005
`define IDX_GPIO_IN 10'h006
`define IDX_STRAPS 10'h007
`define IDX_SETUP_DONE 10'h0ff
// Config register fields
`define CFG_BC_LSB 0
`define CFG_DUAL_BIT 8
`define CFG_MODE3_BIT 9
`define CFG_RESET 32'h0000_0000
// Strap level codes, in order of resistor strength
`define LVL_STRONG_UP 3'h1
// Flash probe
`define FLASH_SIG 32'h3244_4655
`define FLASH_SIG_ADDR 24'h00fffa
`define FLASH_CODE_ADDR 24'h000000
`define FLASH_CMD_READ 8'h03
`define FLASH_CMD_DUAL 8'h3b
`define FLASH_HALF 4
`define DS_PORTS_ON 6'h3f
`endif

// >>> verilog/hub_boot_pkg.sv
// Types shared by the boot sequencer and its helpers.
// Assumes hub_boot_cfg.svh for numeric constants.
package hub_boot_pkg;
  // Boot stages, one-hot
  typedef enum logic [10:0] {
    ST_STANDBY = 11'h001,
    ST_PROBE = 11'h002,
    ST_DEFLOAD = 11'h004,
    ST_STRAP = 11'h008,
    ST_SOC_CFG = 11'h010,
    ST_MERGE = 11'h020,
    ST_IDLE = 11'h040,
    ST_SUSPEND = 11'h080,
    ST_CHG_DET = 11'h100,
    ST_CONNECT = 11'h200,
    ST_NORMAL = 11'h400
  } stage_t;
  // Strap pin levels; the two 3-bit fields are six-level codes 0..5, spi_mode is one bit
  typedef struct packed {
    logic spi_mode;
    logic [2:0] smbus_target_setting;
    logic [2:0] charge_port_count_strap;
  } straps_t;
  // One-time-programmable overrides
  typedef struct packed {
    logic valid;
    logic [5:0] bc_mask;
  } otp_t;
  // Feature controller write request
  typedef struct packed {
    logic valid;
    logic [9:0] idx;
    logic [31:0] data;
  } fc_wr_t;
  // Charge level code to enabled charging ports
  function automatic logic [5:0] bc_mask(input logic [2:0] lvl);
    case (lvl)
      3'h0: bc_mask = 6'h00;
      3'h1: bc_mask = 6'h01;
      3'h2: bc_mask = 6'h03;
      3'h3: bc_mask = 6'h07;
      3'h4: bc_mask = 6'h0f;
      3'h5: bc_mask = 6'h3f;
      default: bc_mask = 6'h00;
    endcase
  endfunction
endpackage

// >>> verilog/gpio_bank.sv
// Pin drivers for general purpose pins, with input synchronisers.
// Assumes the caller holds rst high in standby so all pins float.
`timescale 1ns/10ps
module gpio_bank #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] dir,
  input wire logic [N-1:0] out_val,
  input wire logic [N-1:0] pull_en,
  input wire logic [N-1:0] pull_up,
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] pin_out,
  output logic [N-1:0] pin_oe_n,
  output logic [N-1:0] pin_pu,
  output logic [N-1:0] pin_pd,
  output logic [N-1:0] in_sync
);
  logic [N-1:0] meta; // First stage, read only by in_sync

  initial begin
    if (N < 1 || N > 32) $error("gpio_bank: N must be 1..32");
  end

  // Per-pin driver flops
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : pin
      always_ff @(posedge clk) begin
        if (rst) begin
          pin_oe_n[g] <= 1'b1; // Floating in standby
          pin_out[g] <= 1'b0;
          pin_pu[g] <= 1'b0;
          pin_pd[g] <= 1'b0;
        end else begin
          pin_oe_n[g] <= ~dir[g];
          pin_out[g] <= out_val[g];
          pin_pu[g] <= ~dir[g] & pull_en[g] & pull_up[g];
          pin_pd[g] <= ~dir[g] & pull_en[g] & ~pull_up[g];
        end
      end
    end
  endgenerate

  // Two-stage input synchroniser
  always_ff @(posedge clk) begin
    meta <= pin_in;
    in_sync <= meta;
  end
endmodule

// >>> verilog/flash_probe.sv
// Serial flash signature probe, single or dual bit, clock mode 0 or 3.
// Assumes a flash that shifts data on the falling clock edge.
`timescale 1ns/10ps
`include "hub_boot_cfg.svh"
module flash_probe #(
  parameter int HALF = `FLASH_HALF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic dual,
  input wire logic mode3,
  input wire logic io0_in,
  input wire logic io1_in,
  output logic done,
  output logic found,
  output logic cs_n,
  output logic sck,
  output logic io0_out,
  output logic io0_oe_n,
  output logic if_oe_n
);
  logic [1:0] m0, m1; // Synchroniser first stages
  logic io0_s, io1_s;
  logic busy;
  logic ph; // High phase of serial clock
  logic [7:0] div;
  logic [6:0] cnt; // Serial clocks done
  logic [31:0] tx;
  logic [31:0] rx;
  logic [31:0] next_rx;
  logic [6:0] last;
  localparam logic [7:0] CMD_RD = `FLASH_CMD_READ; // Sized so one bit can be picked
  localparam logic [7:0] CMD_DUAL = `FLASH_CMD_DUAL;

  initial begin
    if (HALF < 3 || HALF > 255) $error("flash_probe: HALF must be 3..255");
  end

  // Pins pass three flops; sample lands 3 cycles late, still inside the bit
  always_ff @(posedge clk) begin
    m0 <= {m0[0], io0_in};
    m1 <= {m1[0], io1_in};
    io0_s <= m0[1];
    io1_s <= m1[1];
  end

  // Dual read adds 8 dummy clocks and halves the data clocks
  assign last = dual ? 7'd55 : 7'd63;
  always_comb begin
    next_rx = dual ? {rx[29:0], io1_s, io0_s} : {rx[30:0], io1_s};
  end

  // Transfer sequencer
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      cs_n <= 1'b1;
      sck <= 1'b0;
      io0_out <= 1'b0;
      io0_oe_n <= 1'b1;
      if_oe_n <= 1'b1; // Tri-stated in standby
      found <= 1'b0;
      ph <= 1'b0;
      div <= 8'h00;
      cnt <= 7'h00;
      tx <= 32'h0;
      rx <= 32'h0;
    end else begin
      if_oe_n <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        cs_n <= 1'b0;
        sck <= 1'b0; // Mode 3 idles high, first edge falls
        ph <= 1'b0;
        div <= 8'h00;
        cnt <= 7'h00;
        tx <= {dual ? `FLASH_CMD_DUAL : `FLASH_CMD_READ, `FLASH_SIG_ADDR};
        io0_out <= dual ? CMD_DUAL[7] : CMD_RD[7]; // First command bit
        io0_oe_n <= 1'b0;
        found <= 1'b0;
      end else if (busy) begin
        if (div == 8'(HALF - 1)) begin
          div <= 8'h00;
          ph <= ~ph;
          sck <= ~ph;
          if (ph) begin
            // End of high phase: sample, then shift next bit
            if (cnt > (dual ? 7'd39 : 7'd31)) begin
              rx <= next_rx;
            end
            tx <= {tx[30:0], 1'b0};
            io0_out <= tx[30];
            if (dual && cnt == 7'd31) begin
              io0_oe_n <= 1'b1; // Release io0 for dual data
            end
            cnt <= cnt + 7'd1;
            if (cnt == last) begin
              busy <= 1'b0;
              cs_n <= 1'b1;
              sck <= mode3;
              io0_oe_n <= 1'b1;
              done <= 1'b1;
              found <= (next_rx == `FLASH_SIG);
            end
          end
        end else begin
          div <= div + 8'h01;
        end
      end else begin
        sck <= mode3;
      end
    end
  end

  // Select stays low for the whole transfer
  property p_cs_held;
    @(posedge clk) disable iff (rst)
    busy && !done |-> !cs_n;
  endproperty
  a_cs_held: assert property (p_cs_held) else $error("flash select rose mid transfer");

  // Found only reported with completion and a signature match
  property p_found_sig;
    @(posedge clk) disable iff (rst)
    $rose(found) |-> done && rx == `FLASH_SIG;
  endproperty
  a_found_sig: assert property (p_found_sig) else $error("signature flag without match");
endmodule

// >>> verilog/hub_boot_mode_sequencer.sv
// Hub mode and boot-stage sequencer with its AHB-Lite register window.
// Assumes one 100 MHz clock; chip reset, straps and pin levels are asynchronous.
`timescale 1ns/10ps
`include "hub_boot_cfg.svh"
module hub_boot_mode_sequencer import hub_boot_pkg::*; #(
  parameter int GPIO_N = 8,
  parameter int FLASH_HALF = `FLASH_HALF,
  parameter logic [5:0] BC_DEFAULT = 6'h00
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CHIP_RESET_N,
  input wire logic VBUS,
  input wire logic CONNECT_REQ,
  input wire logic PLL_LOCK,
  input wire logic SMB_DATA_PULLUP,
  input wire logic SMB_CLK_PULLUP,
  input wire straps_t STRAPS,
  input wire otp_t OTP,
  input wire logic CHG_DET_DONE,
  input wire logic ENUMERATED,
  input wire fc_wr_t FC_WR,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  output stage_t STAGE,
  output logic PLL_RUN,
  output logic [5:0] DS_PORT_EN,
  output logic [5:0] BC_PORT_EN,
  output logic SMBUS_SLAVE_EN,
  output logic CFG_APPLIED,
  output logic SUSPEND,
  output logic CHG_DET_START,
  output logic UPSTREAM_CONNECT,
  output logic EXT_CODE_RUN,
  output logic FC_WR_READY,
  output logic FLASH_CS_N,
  output logic FLASH_SCK,
  output logic FLASH_IO0_OUT,
  output logic FLASH_IO0_OE_N,
  output logic FLASH_IF_OE_N,
  input wire logic FLASH_IO0_IN,
  input wire logic FLASH_IO1_IN,
  input wire logic [GPIO_N-1:0] GPIO_IN,
  output logic [GPIO_N-1:0] GPIO_OUT,
  output logic [GPIO_N-1:0] GPIO_OE_N,
  output logic [GPIO_N-1:0] GPIO_PU,
  output logic [GPIO_N-1:0] GPIO_PD
);
  localparam int PW = 13; // Asynchronous pin levels
  logic [PW-1:0] pin_meta; // First stage, read only by pin_sync
  logic [PW-1:0] pin_sync;
  logic rst_n_s, vbus_s, creq_s, lock_s, smbd_s, smbc_s;
  straps_t straps_s;
  straps_t cap; // Straps latched at release
  stage_t stage;
  logic clr; // Power-on or standby reset of all state
  logic probe_go, probe_done, probe_found, probe_started;
  logic [31:0] config_reg; // SoC-written configuration
  logic soc_set; // SoC touched the config
  logic [GPIO_N-1:0] gpio_dir, gpio_out, gpio_pull_en, gpio_pull_up, gpio_in_s;
  logic ap_wr; // Pending write data phase
  logic [9:0] ap_idx;
  logic ap_ok; // Address within window
  logic setup_wr; // Write to the setup-done index this cycle
  logic ahb_take;
  logic smb_target;

  initial begin
    if (GPIO_N < 1 || GPIO_N > 32) $error("GPIO_N must be 1..32");
  end

  // In-window and word-aligned check of an address, decode shared by read and write
  function automatic logic in_window(input logic [31:0] a);
    in_window = (a[31:12] == 20'h0) && (a[1:0] == 2'b00);
  endfunction

  // Register read mux
  function automatic logic [31:0] rd_mux(input logic [9:0] idx);
    case (idx)
      `IDX_STAGE: rd_mux = 32'(stage);
      `IDX_CONFIG: rd_mux = config_reg;
      `IDX_GPIO_DIR: rd_mux = 32'(gpio_dir);
      `IDX_GPIO_OUT: rd_mux = 32'(gpio_out);
      `IDX_GPIO_PULL_EN: rd_mux = 32'(gpio_pull_en);
      `IDX_GPIO_PULL_UP: rd_mux = 32'(gpio_pull_up);
      `IDX_GPIO_IN: rd_mux = 32'(gpio_in_s);
      `IDX_STRAPS: rd_mux = 32'(cap);
      default: rd_mux = 32'h0; // Unmapped and write-only read zero
    endcase
  endfunction

  // Two flops on every pin level before any logic
  always_ff @(posedge REF_CLK) begin
    pin_meta <= {CHIP_RESET_N, VBUS, CONNECT_REQ, PLL_LOCK, SMB_DATA_PULLUP, SMB_CLK_PULLUP, STRAPS};
    pin_sync <= pin_meta;
  end
  assign {rst_n_s, vbus_s, creq_s, lock_s, smbd_s, smbc_s, straps_s} = pin_sync;

  // Low chip reset clears everything, nothing survives standby
  assign clr = RST | ~rst_n_s;
  assign smb_target = (cap.smbus_target_setting == `LVL_STRONG_UP);
  assign ahb_take = HSEL & HTRANS[1] & HREADY;
  assign setup_wr = ap_wr & ap_ok & (ap_idx == `IDX_SETUP_DONE);

  // Strap capture on the release edge, values held until next standby
  always_ff @(posedge REF_CLK) begin
    if (clr) begin
      cap <= '0;
    end else if (stage == ST_STANDBY) begin
      cap <= straps_s;
    end
  end

  // Boot stage machine
  always_ff @(posedge REF_CLK) begin
    probe_go <= 1'b0;
    if (clr) begin
      stage <= ST_STANDBY;
      probe_started <= 1'b0;
    end else begin
      case (stage)
        ST_STANDBY: begin
          stage <= ST_PROBE;
        end
        ST_PROBE: begin
          if (!cap.spi_mode) begin
            if (lock_s) stage <= ST_DEFLOAD;
          end else if (!probe_started && lock_s) begin
            probe_go <= 1'b1;
            probe_started <= 1'b1;
          end else if (probe_done) begin
            stage <= ST_DEFLOAD;
          end
        end
        ST_DEFLOAD: stage <= ST_STRAP;
        ST_STRAP: begin
          if (smb_target && smbd_s && smbc_s) begin
            stage <= ST_SOC_CFG;
          end else begin
            stage <= ST_MERGE;
          end
        end
        ST_SOC_CFG: begin
          if (setup_wr) stage <= ST_MERGE;
        end
        ST_MERGE: stage <= ST_IDLE;
        ST_IDLE, ST_SUSPEND: begin
          if (vbus_s) begin
            stage <= (BC_PORT_EN != 6'h00) ? ST_CHG_DET : ST_CONNECT;
          end else if (!creq_s) begin
            stage <= ST_SUSPEND;
          end
        end
        ST_CHG_DET: begin
          if (CHG_DET_DONE) stage <= ST_CONNECT;
        end
        ST_CONNECT: begin
          if (!vbus_s) stage <= ST_IDLE;
          else if (ENUMERATED) stage <= ST_NORMAL;
        end
        ST_NORMAL: begin
          if (!vbus_s) stage <= ST_IDLE;
        end
        default: stage <= ST_STANDBY;
      endcase
    end
  end

  // Stage outputs; all quiet while in standby
  always_ff @(posedge REF_CLK) begin
    if (clr) begin
      STAGE <= ST_STANDBY;
      PLL_RUN <= 1'b0;
      DS_PORT_EN <= 6'h00;
      SUSPEND <= 1'b0;
      CHG_DET_START <= 1'b0;
      UPSTREAM_CONNECT <= 1'b0;
      FC_WR_READY <= 1'b0;
      EXT_CODE_RUN <= 1'b0;
    end else begin
      STAGE <= stage;
      PLL_RUN <= 1'b1;
      DS_PORT_EN <= (stage == ST_CONNECT || stage == ST_NORMAL) ? `DS_PORTS_ON : 6'h00;
      SUSPEND <= (stage == ST_SUSPEND);
      CHG_DET_START <= (stage == ST_CHG_DET);
      UPSTREAM_CONNECT <= (stage == ST_CONNECT || stage == ST_NORMAL) && vbus_s;
      FC_WR_READY <= (stage == ST_NORMAL);
      if (probe_done && probe_found) EXT_CODE_RUN <= 1'b1;
    end
  end

  // Default load, strap override, then merge with OTP and SoC data
  always_ff @(posedge REF_CLK) begin
    if (clr) begin
      BC_PORT_EN <= 6'h00;
      SMBUS_SLAVE_EN <= 1'b0;
      CFG_APPLIED <= 1'b0;
    end else begin
      if (stage == ST_DEFLOAD) begin
        BC_PORT_EN <= BC_DEFAULT;
        if (cap.charge_port_count_strap <= 3'h5) begin
          BC_PORT_EN <= bc_mask(cap.charge_port_count_strap);
        end
        SMBUS_SLAVE_EN <= smb_target;
      end
      if (stage == ST_MERGE) begin
        if (soc_set) begin
          BC_PORT_EN <= config_reg[`CFG_BC_LSB +: 6];
        end else if (OTP.valid) begin
          BC_PORT_EN <= OTP.bc_mask;
        end
        CFG_APPLIED <= 1'b1;
      end
    end
  end

  // SoC configuration register, writable only during setup
  always_ff @(posedge REF_CLK) begin
    if (clr) begin
      config_reg <= `CFG_RESET;
      soc_set <= 1'b0;
    end else if (ap_wr && ap_ok && ap_idx == `IDX_CONFIG && stage == ST_SOC_CFG) begin
      config_reg <= HWDATA;
      soc_set <= 1'b1;
    end
  end

  // Pin configuration: feature controller first, bus write same cycle wins
  always_ff @(posedge REF_CLK) begin
    if (clr) begin
      gpio_dir <= '0;
      gpio_out <= '0;
      gpio_pull_en <= '0;
      gpio_pull_up <= '0;
    end else if (stage == ST_NORMAL) begin
      if (FC_WR.valid) begin
        case (FC_WR.idx)
          `IDX_GPIO_DIR: gpio_dir <= FC_WR.data[GPIO_N-1:0];
          `IDX_GPIO_OUT: gpio_out <= FC_WR.data[GPIO_N-1:0];
          `IDX_GPIO_PULL_EN: gpio_pull_en <= FC_WR.data[GPIO_N-1:0];
          `IDX_GPIO_PULL_UP: gpio_pull_up <= FC_WR.data[GPIO_N-1:0];
          default: ; // Other indices not bridged
        endcase
      end
      if (ap_wr && ap_ok) begin
        case (ap_idx)
          `IDX_GPIO_DIR: gpio_dir <= HWDATA[GPIO_N-1:0];
          `IDX_GPIO_OUT: gpio_out <= HWDATA[GPIO_N-1:0];
          `IDX_GPIO_PULL_EN: gpio_pull_en <= HWDATA[GPIO_N-1:0];
          `IDX_GPIO_PULL_UP: gpio_pull_up <= HWDATA[GPIO_N-1:0];
          default: ;
        endcase
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge REF_CLK) begin
    if (clr) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0;
      ap_wr <= 1'b0;
      ap_idx <= 10'h000;
      ap_ok <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      ap_wr <= ahb_take & HWRITE;
      ap_idx <= HADDR[11:2];
      ap_ok <= in_window(HADDR);
      if (ahb_take && !HWRITE) begin
        HRDATA <= in_window(HADDR) ? rd_mux(HADDR[11:2]) : 32'h0; // Read captured at address phase
      end
    end
  end

  flash_probe #(.HALF(FLASH_HALF)) u_flash (
    .clk(REF_CLK),
    .rst(clr),
    .start(probe_go),
    .dual(config_reg[`CFG_DUAL_BIT]),
    .mode3(config_reg[`CFG_MODE3_BIT]),
    .io0_in(FLASH_IO0_IN),
    .io1_in(FLASH_IO1_IN),
    .done(probe_done),
    .found(probe_found),
    .cs_n(FLASH_CS_N),
    .sck(FLASH_SCK),
    .io0_out(FLASH_IO0_OUT),
    .io0_oe_n(FLASH_IO0_OE_N),
    .if_oe_n(FLASH_IF_OE_N)
  );

  gpio_bank #(.N(GPIO_N)) u_gpio (
    .clk(REF_CLK),
    .rst(clr),
    .dir(gpio_dir),
    .out_val(gpio_out),
    .pull_en(gpio_pull_en),
    .pull_up(gpio_pull_up),
    .pin_in(GPIO_IN),
    .pin_out(GPIO_OUT),
    .pin_oe_n(GPIO_OE_N),
    .pin_pu(GPIO_PU),
    .pin_pd(GPIO_PD),
    .in_sync(gpio_in_s)
  );

  // Low chip reset forces standby next cycle from any stage
  property p_to_standby;
    @(posedge REF_CLK) disable iff (RST)
    !rst_n_s |=> stage == ST_STANDBY;
  endproperty
  a_to_standby: assert property (p_to_standby) else $error("no standby after chip reset");

  property p_onehot;
    @(posedge REF_CLK) disable iff (RST)
    $onehot(stage);
  endproperty
  a_onehot: assert property (p_onehot) else $error("stage not one-hot");

  property p_standby_quiet;
    @(posedge REF_CLK) disable iff (RST)
    stage == ST_STANDBY |-> !PLL_RUN && DS_PORT_EN == 6'h00 && &GPIO_OE_N && FLASH_IF_OE_N;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("standby outputs active");

  property p_strap_branch;
    @(posedge REF_CLK) disable iff (clr)
    stage == ST_STRAP |=> stage == ((smb_target && $past(smbd_s) && $past(smbc_s)) ? ST_SOC_CFG : ST_MERGE);
  endproperty
  a_strap_branch: assert property (p_strap_branch) else $error("wrong strap stage exit");

  property p_soc_hold;
    @(posedge REF_CLK) disable iff (clr)
    stage == ST_SOC_CFG && !setup_wr |=> stage == ST_SOC_CFG;
  endproperty
  a_soc_hold: assert property (p_soc_hold) else $error("setup left without done write");

  property p_soc_done;
    @(posedge REF_CLK) disable iff (clr)
    stage == ST_SOC_CFG && setup_wr |=> stage == ST_MERGE ##1 CFG_APPLIED;
  endproperty
  a_soc_done: assert property (p_soc_done) else $error("done write did not reach merge");

  property p_bc_decode;
    @(posedge REF_CLK) disable iff (clr)
    stage == ST_MERGE && !soc_set && !OTP.valid |=> BC_PORT_EN == bc_mask(cap.charge_port_count_strap);
  endproperty
  a_bc_decode: assert property (p_bc_decode) else $error("charge mask mismatch");

  property p_connect_hold;
    @(posedge REF_CLK) disable iff (clr)
    stage == ST_CONNECT && vbus_s && !ENUMERATED |=> stage == ST_CONNECT && UPSTREAM_CONNECT;
  endproperty
  a_connect_hold: assert property (p_connect_hold) else $error("connect stage left with VBUS");

  property p_fc_route;
    @(posedge REF_CLK) disable iff (clr)
    stage == ST_NORMAL && FC_WR.valid && FC_WR.idx == `IDX_GPIO_DIR && !(ap_wr && ap_ok && ap_idx == `IDX_GPIO_DIR)
      |=> ##1 GPIO_OE_N == ~$past(FC_WR.data[GPIO_N-1:0], 2);
  endproperty
  a_fc_route: assert property (p_fc_route) else $error("bridged direction not applied");
endmodule

// >>> verification/flash_model.sv
// Behavioural serial flash answering a single-bit read.
// Assumes a probe that sends a command byte and three address bytes.
`timescale 1ns/10ps
`include "hub_boot_cfg.svh"
module flash_model (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic good,
  output logic io1
);
  logic [5:0] n; // Rising clocks in this frame
  logic [31:0] sig; // Word still to shift
  initial io1 = 1'b0;
  // Header count; deselect restarts it; no rate limit, any size holds it
  always @(posedge sck or posedge cs_n) begin
    if (cs_n) n <= 6'h00;
    else if (n != 6'h3f) n <= n + 6'h01;
  end
  // Shift on the falling edge, MSB first; works for idle-low and idle-high clock
  always @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      io1 <= ~io1; // Deselect inverts io1 rather than releasing it
    end else if (n == 6'h01) begin
      sig <= good ? `FLASH_SIG : ~`FLASH_SIG; // Bad image breaks every byte
    end else if (n >= 6'h20) begin
      io1 <= sig[31];
      sig <= {sig[30:0], 1'b0};
    end
  end
endmodule

// >>> verification/hub_boot_mode_sequencer_test.sv
// Bench for the boot sequencer: strap table, SoC setup, flash probe, pins, standby.
// Assumes the bench is the only AHB master and the flash model answers the probe.
`timescale 1ns/10ps
module hub_boot_mode_sequencer_test import hub_boot_pkg::*;;
  logic clk, rst, chip_n, vbus, lock, pu, good, cdone, enu, hsel, hwrite, hready;
  logic pll, ext, up, smb, io1, cs_n, sck, io0, io0_oe_n, if_oe_n;
  logic creq, cfgd, susp, cds, fcr, hresp;
  otp_t otp;
  fc_wr_t fc;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [5:0] ds, bc;
  logic [7:0] gout, goe_n, gpu, gpd;
  stage_t stage;
  straps_t straps;
  int fails = 0;
  int n_compared = 0;
  logic [5:0] m [6] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0f, 6'h3f}; // Ports per strap level
  hub_boot_mode_sequencer i_hub_boot_mode_sequencer (
    .REF_CLK(clk), .RST(rst), .CHIP_RESET_N(chip_n), .VBUS(vbus), .CONNECT_REQ(creq), .PLL_LOCK(lock),
    .SMB_DATA_PULLUP(pu), .SMB_CLK_PULLUP(pu), .STRAPS(straps), .OTP(otp), .CHG_DET_DONE(cdone),
    .ENUMERATED(enu), .FC_WR(fc), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata),
    .STAGE(stage), .PLL_RUN(pll), .DS_PORT_EN(ds), .BC_PORT_EN(bc), .SMBUS_SLAVE_EN(smb), .CFG_APPLIED(cfgd),
    .SUSPEND(susp), .CHG_DET_START(cds), .UPSTREAM_CONNECT(up), .EXT_CODE_RUN(ext), .FC_WR_READY(fcr),
    .FLASH_CS_N(cs_n), .FLASH_SCK(sck), .FLASH_IO0_OUT(io0), .FLASH_IO0_OE_N(io0_oe_n),
    .FLASH_IF_OE_N(if_oe_n), .FLASH_IO0_IN(~io0), .FLASH_IO1_IN(io1), .GPIO_IN(8'h00),
    .GPIO_OUT(gout), .GPIO_OE_N(goe_n), .GPIO_PU(gpu), .GPIO_PD(gpd));
  flash_model i_flash_model (.cs_n(cs_n), .sck(sck), .good(good), .io1(io1));
  // Value compare
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  // Stage compare
  task automatic chk_st(input stage_t e);
    chk(32'(stage), 32'(e));
  endtask
  // Bounded wait, sampled mid-cycle where the stage is settled
  task automatic wait_st(input stage_t e);
    for (int k = 0; k < 3000 && stage !== e; k++) @(negedge clk);
    chk_st(e);
    @(posedge clk);
  endtask
  // One AHB-Lite single transfer; waits on ready, never on a fixed count
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Standby with new straps, release, PLL locks a little later
  task automatic boot(input straps_t s, input logic g);
    chip_n <= 1'b0;
    lock <= 1'b0;
    straps <= s;
    good <= g;
    repeat (4) @(posedge clk);
    chip_n <= 1'b1;
    repeat (6) @(posedge clk);
    lock <= 1'b1;
  endtask
  task automatic give_verdict;
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog well past the longest run
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    give_verdict;
  end
  initial begin
    {rst, chip_n, vbus, lock, pu, good, cdone, enu, hsel, hwrite, creq} = 11'h400;
    {htrans, haddr, hwdata, otp, fc} = '0;
    straps = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Rows: strap level in, port mask and VBUS path out
    for (int i = 0; i < 6; i++) begin
      boot({1'b0, 3'h0, 3'(i)}, 1'b0);
      wait_st(ST_SUSPEND);
      chk(bc, m[i]);
      chk(pll, 1'b1);
      chk({cfgd, susp}, 2'h3);
      vbus <= 1'b1;
      wait_st(m[i] != 6'h00 ? ST_CHG_DET : ST_CONNECT);
      chk(cds, m[i] != 6'h00);
      cdone <= 1'b1;
      wait_st(ST_CONNECT);
      chk({up, ds}, 7'h7f);
      vbus <= 1'b0;
      cdone <= 1'b0;
      wait_st(ST_IDLE);
    end
    // Good image, SoC setup held open until the done write
    pu <= 1'b1;
    boot({1'b1, 3'h1, 3'h2}, 1'b1);
    wait_st(ST_SOC_CFG);
    chk({ext, smb}, 2'h3);
    ahb(1'b1, 32'h4, 32'h3c, q);
    repeat (200) @(posedge clk);
    ahb(1'b0, 32'h0, 32'h0, q);
    chk(q, 32'(ST_SOC_CFG));
    ahb(1'b1, 32'h3fc, 32'h0, q);
    wait_st(ST_SUSPEND);
    chk(bc, 6'h3c);
    // Bad image, unmapped read, pins set in normal operation
    pu <= 1'b0;
    boot({1'b1, 3'h1, 3'h0}, 1'b0);
    wait_st(ST_SUSPEND);
    chk({ext, smb}, 2'h1);
    ahb(1'b0, 32'h1000, 32'h0, q);
    chk(q, 32'h0);
    chk(hresp, 1'b0);
    vbus <= 1'b1;
    wait_st(ST_CONNECT);
    enu <= 1'b1;
    wait_st(ST_NORMAL);
    chk(fcr, 1'b1);
    ahb(1'b1, 32'h8, 32'h0f, q);
    ahb(1'b1, 32'hc, 32'h05, q);
    ahb(1'b1, 32'h10, 32'hf0, q);
    ahb(1'b1, 32'h14, 32'h30, q);
    repeat (3) @(posedge clk);
    chk({goe_n, gout[3:0], gpu, gpd}, 28'hf0530c0);
    // Bridged write from the feature controller, one-cycle pulse
    fc <= {1'b1, 10'h002, 32'h0000_0003};
    @(posedge clk);
    fc <= '0;
    repeat (2) @(posedge clk);
    chk(goe_n, 8'hfc);
    // Standby: pins float, ports off, setup forgotten
    chip_n <= 1'b0;
    repeat (4) @(negedge clk);
    chk_st(ST_STANDBY);
    chk({pll, ds, goe_n, if_oe_n}, 16'h01ff);
    @(posedge clk);
    enu <= 1'b0;
    vbus <= 1'b0;
    creq <= 1'b1;
    otp <= {1'b1, 6'h15};
    boot('0, 1'b0);
    // Connect request holds idle; OTP mask wins over the strap
    wait_st(ST_IDLE);
    repeat (20) @(negedge clk);
    chk_st(ST_IDLE);
    chk(bc, 6'h15);
    @(posedge clk);
    creq <= 1'b0;
    wait_st(ST_SUSPEND);
    ahb(1'b0, 32'h8, 32'h0, q);
    chk(q, 32'h0);
    give_verdict;
  end
endmodule
